// ---- common/pia_pkg.sv ----
// Package of constants for the interrupt aggregator
`default_nettype none
package pia_pkg;
   localparam int unsigned GROUPS = 4;
   localparam int unsigned GROUP_W = 8;
   localparam logic [1:0] GRP_A = 2'h0;
   localparam logic [1:0] GRP_B = 2'h1;
   localparam logic [1:0] GRP_C = 2'h2;
   localparam logic [1:0] GRP_D = 2'h3;
   localparam logic [7:0] STATUS_RESET = 8'h00;
   localparam logic [7:0] BLOCK_RESET = 8'h00;
   localparam logic [7:0] EDGE_SEL_RESET = 8'h00;
   localparam logic POLARITY_RESET = 1'h0;
   localparam logic CLEAR_ON_WRITE_RESET = 1'h0;
   localparam logic PENDING_RESET = 1'h0;
   localparam logic WAKE_IN_SLEEP_RESET = 1'h0;
   localparam logic [7:0] ALL_ONES = 8'hFF;
endpackage
`default_nettype wire

// ---- dv/pia_aggregator_tb_top.sv ----
// Testbench of the interrupt aggregator
`default_nettype none
module pia_aggregator_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk_in, rst_n_in, pol, cow, pend, wis, slp_st, slp_rq;
   logic rd, wr, alert, sgo;
   logic [1:0] grp;
   logic [7:0] wd, rdl, rdv, lvl_d, prim, rise, fall;
   logic [7:0] ev [3];
   logic [7:0] live [3];
   logic [7:0] blk [4];
   int n_mismatch, compares;
   pia_aggregator #(.WIDTH(8)) i_dut (.clk_in(clk_in), .rst_n_in(rst_n_in),
      .event_group_a_in(ev[0]), .event_group_b_in(ev[1]),
      .event_group_c_in(ev[2]), .event_group_d_level_in(lvl_d),
      .live_a_in(live[0]), .live_b_in(live[1]), .live_c_in(live[2]),
      .pin_primary_in(prim), .block_a_in(blk[0]), .block_b_in(blk[1]),
      .block_c_in(blk[2]), .block_d_in(blk[3]),
      .pin_group_rise_select_in(rise), .pin_group_fall_select_in(fall),
      .alert_active_high_in(pol), .clear_on_write_in(cow),
      .pending_enable_in(pend), .wake_in_sleep_in(wis),
      .sleep_state_in(slp_st), .sleep_request_in(slp_rq), .rd_in(rd),
      .wr_in(wr), .rd_group_in(grp), .wr_data_in(wd), .rd_latch_out(rdl),
      .rd_live_out(rdv), .alert_out(alert), .sleep_go_out(sgo));
   pia_host_model i_host (.clk_in(clk_in), .alert_in(alert),
      .active_high_in(pol), .rd_out(rd), .wr_out(wr), .group_out(grp),
      .data_out(wd));
   initial begin
      clk_in = 1'h0;
      forever #50 clk_in = ~clk_in;
   end
   task automatic print_verdict();
      $display("compares %0d mismatches %0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   task automatic chk(string name, logic [7:0] seen, logic [7:0] exp);
      compares++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[ERR] %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic cyc(int n);
      repeat (n) @(posedge clk_in);
      #1;
   endtask
   task automatic pulse(int g, logic [7:0] b);
      @(posedge clk_in);
      ev[g] <= b;
      @(posedge clk_in);
      ev[g] <= 8'h00;
      cyc(3);
   endtask
   task automatic rd_chk(logic [1:0] g, logic [7:0] exp);
      i_host.access(1'h0, g, 8'h00);
      chk("latch", rdl, exp);
   endtask
   // Alert at active (1) or idle (0) level within a bound
   task automatic alert_is(logic on);
      int i;
      for (i = 0; i < 10 && alert !== (on ~^ pol); i++) cyc(1);
      chk("alert", {7'h00, alert}, {7'h00, on ~^ pol});
      if (i == 10) print_verdict();
   endtask
   initial begin
      {rst_n_in, pol, cow, pend, wis, slp_st} = 6'h00;
      slp_rq = 1'h1;
      {lvl_d, rise, fall} = 24'h000000;
      prim = 8'hFF;
      foreach (ev[g]) ev[g] = 8'h00;
      foreach (live[g]) live[g] = 8'h00;
      foreach (blk[g]) blk[g] = 8'h00;
      n_mismatch = 0;
      compares = 0;
      repeat (20) @(posedge clk_in);
      rst_n_in <= 1'h1;
      live[1] <= 8'h5A;
      cyc(1);
      chk("alert_rst", {7'h00, alert}, 8'h01);
      pulse(0, 8'h01);
      alert_is(1'h1);
      chk("sleep_veto", {7'h00, sgo}, 8'h00);
      pulse(1, 8'h08);
      rd_chk(2'h0, 8'h01);
      cyc(2);
      alert_is(1'h1);
      rd_chk(2'h1, 8'h08);
      chk("live_b", rdv, 8'h5A);
      rd_chk(2'h0, 8'h00);
      alert_is(1'h0);
      cyc(2);
      chk("sleep_go", {7'h00, sgo}, 8'h01);
      @(posedge clk_in);
      blk[0] <= 8'h02;
      pulse(0, 8'h02);
      alert_is(1'h0);
      rd_chk(2'h0, 8'h00);
      pulse(2, 8'h04);
      @(posedge clk_in);
      blk[2] <= 8'h04;
      pulse(2, 8'h04);
      rd_chk(2'h2, 8'h04);
      @(posedge clk_in);
      blk[0] <= 8'h00;
      blk[2] <= 8'h00;
      cow <= 1'h1;
      pulse(0, 8'h21);
      i_host.access(1'h1, 2'h0, 8'h01);
      i_host.access(1'h1, 2'h0, 8'h20);
      rd_chk(2'h0, 8'h20);
      i_host.access(1'h1, 2'h0, 8'hFF);
      rd_chk(2'h0, 8'h00);
      alert_is(1'h0);
      @(posedge clk_in);
      cow <= 1'h0;
      for (int p = 0; p < 2; p++) begin
         @(posedge clk_in);
         pend <= p[0];
         i_host.access(1'h0, 2'h1, 8'h00);
         pulse(0, 8'h01);
         pulse(0, 8'h01);
         pulse(0, 8'h01);
         rd_chk(2'h0, 8'h01);
         i_host.access(1'h0, 2'h1, 8'h00);
         rd_chk(2'h0, (p == 1) ? 8'h01 : 8'h00);
         alert_is(1'h0);
      end
      @(posedge clk_in);
      rise <= 8'h01;
      fall <= 8'h06;
      prim <= 8'hFD;
      @(posedge clk_in);
      lvl_d <= 8'h07;
      cyc(3);
      rd_chk(2'h3, 8'h01);
      chk("live_d", rdv, 8'h07);
      @(posedge clk_in);
      lvl_d <= 8'h00;
      cyc(3);
      i_host.access(1'h0, 2'h0, 8'h00);
      rd_chk(2'h3, 8'h04);
      @(posedge clk_in);
      pol <= 1'h1;
      cyc(2);
      alert_is(1'h0);
      pulse(2, 8'h80);
      alert_is(1'h1);
      i_host.clear_all();
      alert_is(1'h0);
      @(posedge clk_in);
      slp_st <= 1'h1;
      pulse(1, 8'h40);
      alert_is(1'h0);
      @(posedge clk_in);
      wis <= 1'h1;
      pulse(1, 8'h20);
      alert_is(1'h1);
      print_verdict();
   end
endmodule // pia_aggregator_tb_top
`default_nettype wire

// ---- dv/pia_host_model.sv ----
// Host processor model that reads and clears event latches
`default_nettype none
module pia_host_model (
   input wire logic clk_in,
   input wire logic alert_in,
   input wire logic active_high_in,
   output logic rd_out,
   output logic wr_out,
   output logic [1:0] group_out,
   output logic [7:0] data_out
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      rd_out = 1'h0;
      wr_out = 1'h0;
      group_out = 2'h0;
      data_out = 8'h00;
   end
   // One access, held until the taking edge
   task automatic access(input logic w, input logic [1:0] g,
                         input logic [7:0] d);
      @(posedge clk_in);
      rd_out <= ~w;
      wr_out <= w;
      group_out <= g;
      data_out <= d;
      @(posedge clk_in);
      rd_out <= 1'h0;
      wr_out <= 1'h0;
      data_out <= ~d;
      #1;
   endtask
   // Read every group, up to four passes while the alert stays active
   task automatic clear_all();
      // Reads after the alert, repeats up to four times while it stays
      for (int n = 0; n < 4 && alert_in === active_high_in; n++) begin
         for (int g = 0; g < 4; g++) begin
            access(1'h0, 2'(g), 8'h00);
         end
         repeat (3) @(posedge clk_in);
         #1;
      end
   endtask
endmodule // pia_host_model
`default_nettype wire

// ---- rtl/pia_aggregator.sv ----
// Interrupt aggregator of four event groups
//
// Summary of operation
// - Four groups: event latch, block, live level.
// - Live level read returns present line levels.
// - Group d has rise and fall selects.
// - Unmasked latched events OR onto alert.
// - Blocked source records nothing, no alert.
// - Latched bit stays when later blocked.
// - Active alert vetoes sleep sequence.
// - Control selects alert polarity, clear method.
// - Sleep-wake bit allows alert while asleep.
// - Pending mode keeps one repeat; two clears.
// - Back-to-back clears of one register count once.
// - Pending off: repeats during alert discarded.
// - New source latches even while alert active.
// - Alert drops only when no unblocked latch is set, or in sleep without the sleep-wake bit.
// - Clear-on-read clears whole read register.
// - Clear-on-write clears bits written one.
// - Pin events only for primary-function pins.
`default_nettype none
module pia_aggregator #(
   parameter int unsigned WIDTH = 8
) (
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic [WIDTH-1:0] event_group_a_in,
   input wire logic [WIDTH-1:0] event_group_b_in,
   input wire logic [WIDTH-1:0] event_group_c_in,
   input wire logic [WIDTH-1:0] event_group_d_level_in,
   input wire logic [WIDTH-1:0] live_a_in,
   input wire logic [WIDTH-1:0] live_b_in,
   input wire logic [WIDTH-1:0] live_c_in,
   input wire logic [WIDTH-1:0] pin_primary_in,
   input wire logic [WIDTH-1:0] block_a_in,
   input wire logic [WIDTH-1:0] block_b_in,
   input wire logic [WIDTH-1:0] block_c_in,
   input wire logic [WIDTH-1:0] block_d_in,
   input wire logic [WIDTH-1:0] pin_group_rise_select_in,
   input wire logic [WIDTH-1:0] pin_group_fall_select_in,
   input wire logic alert_active_high_in,
   input wire logic clear_on_write_in,
   input wire logic pending_enable_in,
   input wire logic wake_in_sleep_in,
   input wire logic sleep_state_in,
   input wire logic sleep_request_in,
   input wire logic rd_in,
   input wire logic wr_in,
   input wire logic [1:0] rd_group_in,
   input wire logic [WIDTH-1:0] wr_data_in,
   output logic [WIDTH-1:0] rd_latch_out,
   output logic [WIDTH-1:0] rd_live_out,
   output logic alert_out,
   output logic sleep_go_out
);
   typedef struct packed {
      logic [3:0][WIDTH-1:0] latch;
      logic [3:0][WIDTH-1:0] pend;
      logic [WIDTH-1:0] rd_latch;
      logic [WIDTH-1:0] rd_live;
      logic alert;
      logic sleep_go;
   } pia_state_t;

   pia_state_t state_reg;
   pia_state_t state_next;
   logic [3:0][WIDTH-1:0] ev;
   logic [3:0][WIDTH-1:0] blk;
   logic [3:0][WIDTH-1:0] live;
   logic [WIDTH-1:0] pin_ev;
   logic clear_ok;
   logic any_latched;
   logic line_active;

   function automatic logic [WIDTH-1:0] pick(
      input logic [3:0][WIDTH-1:0] v, input logic [1:0] g);
      pick = v[g];
   endfunction

   pia_edge_detect #(.WIDTH(WIDTH)) u_edge (
      .clk_in(clk_in),
      .rst_n_in(rst_n_in),
      .level_in(event_group_d_level_in),
      .rise_sel_in(pin_group_rise_select_in),
      .fall_sel_in(pin_group_fall_select_in),
      .enable_in(pin_primary_in),
      .event_out(pin_ev)
   );

   pia_clear_guard u_guard (
      .clk_in(clk_in),
      .rst_n_in(rst_n_in),
      .access_in(rd_in | wr_in),
      .group_in(rd_group_in),
      .is_clear_in((rd_in & ~clear_on_write_in) |
         (wr_in & clear_on_write_in)),
      .clear_ok_out(clear_ok)
   );

   assign ev = {pin_ev, event_group_c_in, event_group_b_in, event_group_a_in};
   assign blk = {block_d_in, block_c_in, block_b_in, block_a_in};
   assign live = {event_group_d_level_in, live_c_in, live_b_in, live_a_in};

   always_comb begin
      state_next = state_reg;
      any_latched = 1'b0;
      for (int g = 0; g < 4; g++) begin
         any_latched = any_latched | (|state_reg.latch[g]);
      end
      line_active = any_latched;
      for (int g = 0; g < 4; g++) begin
         for (int b = 0; b < WIDTH; b++) begin
            // Clears first, events after so a set wins
            if (clear_ok && rd_group_in == g[1:0]) begin
               if (!clear_on_write_in || wr_data_in[b]) begin
                  if (state_reg.pend[g][b]) begin
                     state_next.pend[g][b] = 1'b0;
                  end else begin
                     state_next.latch[g][b] = 1'b0;
                  end
               end
            end
            if (ev[g][b] && !blk[g][b]) begin
               if (!state_next.latch[g][b]) begin
                  state_next.latch[g][b] = 1'b1;
               end else if (pending_enable_in && line_active) begin
                  state_next.pend[g][b] = 1'b1;
               end // Repeat dropped when pending off
            end
         end
      end
      if (rd_in) begin
         state_next.rd_latch = pick(state_reg.latch, rd_group_in);
         state_next.rd_live = pick(live, rd_group_in);
      end
      any_latched = 1'b0;
      for (int g = 0; g < 4; g++) begin
         any_latched = any_latched |
            (|(state_next.latch[g] & ~blk[g]));
      end
      if (sleep_state_in && !wake_in_sleep_in) begin
         any_latched = 1'b0;
      end
      state_next.alert = any_latched ~^ alert_active_high_in;
      state_next.sleep_go = sleep_request_in && !any_latched;
   end

   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         state_reg <= '0;
         state_reg.alert <= 1'b1;
      end else begin
         state_reg <= state_next;
      end
   end

   assign rd_latch_out = state_reg.rd_latch;
   assign rd_live_out = state_reg.rd_live;
   assign alert_out = state_reg.alert;
   assign sleep_go_out = state_reg.sleep_go;

   a_block_no_set: assert property (@(posedge clk_in)
      disable iff (!rst_n_in)
      (blk[0][0] && !state_reg.latch[0][0]) |=> !state_reg.latch[0][0])
      else $error("blocked source latched");

   a_keep_blocked: assert property (@(posedge clk_in)
      disable iff (!rst_n_in)
      (state_reg.latch[1][0] && !clear_ok) |=> state_reg.latch[1][0])
      else $error("latched bit lost");

   a_new_source_set: assert property (@(posedge clk_in)
      disable iff (!rst_n_in)
      (ev[2][3] && !blk[2][3]) |=> state_reg.latch[2][3])
      else $error("event not latched");

   a_sleep_veto: assert property (@(posedge clk_in)
      disable iff (!rst_n_in)
      state_reg.sleep_go |-> $past(sleep_request_in))
      else $error("sleep without request");

   a_rd_capture: assert property (@(posedge clk_in)
      disable iff (!rst_n_in)
      rd_in |=> rd_latch_out == $past(pick(state_reg.latch, rd_group_in)))
      else $error("read value wrong");

   a_live_read: assert property (@(posedge clk_in)
      disable iff (!rst_n_in)
      rd_in |=> rd_live_out == $past(pick(live, rd_group_in)))
      else $error("live level wrong");

   a_alert_idle: assert property (@(posedge clk_in)
      disable iff (!rst_n_in)
      ($past(state_next.latch) == '0) |->
      alert_out == !$past(alert_active_high_in))
      else $error("alert set while clear");

   a_pend_off: assert property (@(posedge clk_in)
      disable iff (!rst_n_in)
      !pending_enable_in |=> state_reg.pend == $past(state_reg.pend) ||
         $past(clear_ok))
      else $error("pending set while off");

   a_guard_twice: assert property (@(posedge clk_in)
      disable iff (!rst_n_in)
      clear_ok ##1 ((rd_in || wr_in) && rd_group_in == $past(rd_group_in))
      |-> !clear_ok)
      else $error("second clear accepted");

   a_sleep_mask: assert property (@(posedge clk_in)
      disable iff (!rst_n_in)
      (sleep_state_in && !wake_in_sleep_in) |=>
      alert_out == !$past(alert_active_high_in))
      else $error("alert raised in sleep");

   a_sleep_wake: assert property (@(posedge clk_in)
      disable iff (!rst_n_in)
      ((|(state_next.latch[3] & ~blk[3])) && sleep_state_in &&
      wake_in_sleep_in) |=> alert_out == $past(alert_active_high_in))
      else $error("alert missing in sleep");

   a_sleep_free: assert property (@(posedge clk_in)
      disable iff (!rst_n_in)
      (sleep_request_in && state_next.latch == '0) |=> sleep_go_out)
      else $error("sleep refused while clear");

   a_sleep_no_req: assert property (@(posedge clk_in)
      disable iff (!rst_n_in)
      !sleep_request_in |=> !sleep_go_out)
      else $error("sleep allowed unrequested");

   a_reset_alert: assert property (@(posedge clk_in)
      disable iff (!rst_n_in)
      $past(!rst_n_in) |-> alert_out)
      else $error("alert not idle after reset");

   a_rd_hold: assert property (@(posedge clk_in)
      disable iff (!rst_n_in)
      !rd_in |=> $stable(rd_latch_out))
      else $error("read data changed");

   a_live_hold: assert property (@(posedge clk_in)
      disable iff (!rst_n_in)
      !rd_in |=> $stable(rd_live_out))
      else $error("live data changed");

   a_pin_rise: assert property (@(posedge clk_in)
      disable iff (!rst_n_in)
      ($past(rst_n_in) && pin_group_rise_select_in[0] && pin_primary_in[0] &&
      event_group_d_level_in[0] && !$past(event_group_d_level_in[0])) |->
      pin_ev[0])
      else $error("rising pin edge missed");

   a_pin_fall: assert property (@(posedge clk_in)
      disable iff (!rst_n_in)
      ($past(rst_n_in) && pin_group_fall_select_in[2] && pin_primary_in[2] &&
      !event_group_d_level_in[2] && $past(event_group_d_level_in[2])) |->
      pin_ev[2])
      else $error("falling pin edge missed");

   a_pin_off: assert property (@(posedge clk_in)
      disable iff (!rst_n_in)
      !pin_primary_in[1] |-> !pin_ev[1])
      else $error("alternate pin raised event");

   // Checks repeated over groups and bits
   for (genvar gi = 0; gi < 4; gi++) begin : g_grp
      a_cor_clear: assert property (@(posedge clk_in)
         disable iff (!rst_n_in)
         (clear_ok && !clear_on_write_in && rd_group_in == gi &&
         state_reg.pend[gi] == '0 && ev[gi] == '0) |=>
         state_reg.latch[gi] == '0)
         else $error("read did not clear group");

      a_other_kept: assert property (@(posedge clk_in)
         disable iff (!rst_n_in)
         (rd_group_in != gi) |=>
         (state_reg.latch[gi] & $past(state_reg.latch[gi])) ==
         $past(state_reg.latch[gi]))
         else $error("other group cleared");

      a_cow_kept: assert property (@(posedge clk_in)
         disable iff (!rst_n_in)
         (clear_on_write_in && rd_group_in == gi) |=>
         (state_reg.latch[gi] & $past(state_reg.latch[gi] & ~wr_data_in))
         == $past(state_reg.latch[gi] & ~wr_data_in))
         else $error("unwritten bit cleared");

      a_cow_full: assert property (@(posedge clk_in)
         disable iff (!rst_n_in)
         (clear_ok && clear_on_write_in && rd_group_in == gi &&
         wr_data_in == pia_pkg::ALL_ONES && state_reg.pend[gi] == '0 &&
         ev[gi] == '0) |=> state_reg.latch[gi] == '0)
         else $error("full write did not clear");

      a_alert_group: assert property (@(posedge clk_in)
         disable iff (!rst_n_in)
         ((|(state_next.latch[gi] & ~blk[gi])) &&
         !(sleep_state_in && !wake_in_sleep_in)) |=>
         alert_out == $past(alert_active_high_in))
         else $error("alert not raised");

      a_veto_group: assert property (@(posedge clk_in)
         disable iff (!rst_n_in)
         ((|(state_next.latch[gi] & ~blk[gi])) && !sleep_state_in) |=>
         !sleep_go_out)
         else $error("sleep not vetoed");

      for (genvar bi = 0; bi < WIDTH; bi++) begin : g_bit
         a_block_bit: assert property (@(posedge clk_in)
            disable iff (!rst_n_in)
            (blk[gi][bi] && !state_reg.latch[gi][bi]) |=>
            !state_reg.latch[gi][bi])
            else $error("blocked event latched");

         a_set_bit: assert property (@(posedge clk_in)
            disable iff (!rst_n_in)
            (ev[gi][bi] && !blk[gi][bi]) |=> state_reg.latch[gi][bi])
            else $error("open event not latched");

         a_keep_bit: assert property (@(posedge clk_in)
            disable iff (!rst_n_in)
            (state_reg.latch[gi][bi] && !(clear_ok && rd_group_in == gi))
            |=> state_reg.latch[gi][bi])
            else $error("latched bit dropped");

         a_pend_latch: assert property (@(posedge clk_in)
            disable iff (!rst_n_in)
            state_reg.pend[gi][bi] |-> state_reg.latch[gi][bi])
            else $error("pending without latch");

         a_pend_set: assert property (@(posedge clk_in)
            disable iff (!rst_n_in)
            (pending_enable_in && state_reg.latch[gi][bi] && ev[gi][bi] &&
            !blk[gi][bi] && !(clear_ok && rd_group_in == gi)) |=>
            state_reg.pend[gi][bi])
            else $error("repeat not held pending");

         a_pend_first: assert property (@(posedge clk_in)
            disable iff (!rst_n_in)
            (state_reg.pend[gi][bi] && clear_ok && rd_group_in == gi &&
            (!clear_on_write_in || wr_data_in[bi])) |=>
            state_reg.latch[gi][bi])
            else $error("pending latch cleared at once");

         a_discard_bit: assert property (@(posedge clk_in)
            disable iff (!rst_n_in)
            (!pending_enable_in && !state_reg.pend[gi][bi]) |=>
            !state_reg.pend[gi][bi])
            else $error("repeat stored while off");
      end
   end
endmodule // pia_aggregator
`default_nettype wire

// ---- rtl/pia_clear_guard.sv ----
// Gate that blocks a second clear to the same register
`default_nettype none
module pia_clear_guard (
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic access_in,
   input wire logic [1:0] group_in,
   input wire logic is_clear_in,
   output logic clear_ok_out
);
   typedef struct packed {
      logic last_clear;
      logic [1:0] last_group;
   } pia_cg_state_t;
   pia_cg_state_t state_reg;
   pia_cg_state_t state_next;
   always_comb begin
      state_next = state_reg;
      // Back-to-back clears of one register count once
      clear_ok_out = is_clear_in &&
         !(state_reg.last_clear && state_reg.last_group == group_in);
      if (access_in) begin
         state_next.last_clear = is_clear_in;
         state_next.last_group = group_in;
      end
   end
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         state_reg <= '0;
      end else begin
         state_reg <= state_next;
      end
   end
endmodule // pia_clear_guard
`default_nettype wire

// ---- rtl/pia_edge_detect.sv ----
// Edge detector for the pin group
`default_nettype none
module pia_edge_detect #(
   parameter int unsigned WIDTH = 8
) (
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic [WIDTH-1:0] level_in,
   input wire logic [WIDTH-1:0] rise_sel_in,
   input wire logic [WIDTH-1:0] fall_sel_in,
   input wire logic [WIDTH-1:0] enable_in,
   output logic [WIDTH-1:0] event_out
);
   typedef struct packed {
      logic armed;
      logic [WIDTH-1:0] prev;
   } pia_ed_state_t;
   pia_ed_state_t state_reg;
   pia_ed_state_t state_next;
   logic [WIDTH-1:0] rise;
   logic [WIDTH-1:0] fall;
   always_comb begin
      state_next.armed = 1'b1;
      state_next.prev = level_in;
      rise = level_in & ~state_reg.prev;
      fall = ~level_in & state_reg.prev;
      // Primary function pins only, none before first capture
      event_out = ((rise & rise_sel_in) | (fall & fall_sel_in)) &
         enable_in & {WIDTH{state_reg.armed}};
   end
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         state_reg <= '0;
      end else begin
         state_reg <= state_next;
      end
   end
endmodule // pia_edge_detect
`default_nettype wire
